// ---- hdl/pir_top.sv ----
// peripheral interrupt routing: flag sources, pending/enable/priority
// state of the vectored controller, and the request toward the core
// assumes all strobes and conditions are synchronous to core_clk
// assumes the core acks only while irq_valid is high, never on
// consecutive edges, and priority writes carry whole registers
//
// Function
// - thirty-two lines, four priority levels each
// - twenty-five lines each wired to one peripheral
// - flag sets when its condition occurs
// - enable-set ones enable, zeros leave alone
// - enable-clear ones disable, others unchanged
// - request only while flag set and enabled
// - peripheral requests ored into one line
// - request sets pending; software sets or clears
// - line active only when line enabled
// - eight priority registers hold all fields
// - nmi comes from external controller source
// - lines 0-6 system peripherals, 7 reserved
// - line 8 events, 9-14 serial instances
// - 15-17 control timers, 18-22 basic timers
// - 23 adc, 24 comparators, 25 dac; 26-27 reserved
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

module pir_top #(
  parameter int NFLAG = `PIR_NUM_FLAGS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // peripheral side, indexed by controller line
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] periph_cond,
  input wire logic [`PIR_NUM_LINES-1:0] flag_clr_wr,
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] flag_clr_data,
  input wire logic [`PIR_NUM_LINES-1:0] en_set_wr,
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] en_set_data,
  input wire logic [`PIR_NUM_LINES-1:0] en_clr_wr,
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] en_clr_data,
  output logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] irq_flag_status_reg,
  output logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] irq_enable_set_reg,
  output pir_pkg::pir_mask_t periph_req,
  // non-maskable source of the external controller
  input wire logic eic_nmi_cond,
  input wire logic eic_nmi_clr,
  output logic nmi_req,
  // controller pending and line enable controls
  input wire logic pending_set_wr,
  input wire pir_pkg::pir_mask_t pending_set_bits,
  input wire logic pending_clr_wr,
  input wire pir_pkg::pir_mask_t pending_clear_bits,
  input wire logic line_en_set_wr,
  input wire pir_pkg::pir_mask_t line_enable_set_bits,
  input wire logic line_en_clr_wr,
  input wire pir_pkg::pir_mask_t line_enable_clear_bits,
  output pir_pkg::pir_mask_t pending_set_reg,
  output pir_pkg::pir_mask_t line_enable_set_reg,
  // priority registers
  input wire logic prio_wr,
  input wire logic [`PIR_PRIO_REG_IDX_W-1:0] prio_idx,
  input wire logic [31:0] prio_wdata,
  output logic [31:0] prio_rdata,
  // core side
  output logic irq_valid,
  output pir_pkg::pir_line_t irq_line,
  output pir_pkg::pir_prio_t irq_level,
  input wire logic irq_ack
);
  import pir_pkg::*;

  // ========================================================================
  // which lines have a peripheral behind them
  function automatic logic line_wired(input int n);
    line_wired = (n < `PIR_NUM_WIRED)
      && (n != int'(`PIR_LINE_RESERVED_A))
      && (n != int'(`PIR_LINE_RESERVED_B))
      && (n != int'(`PIR_LINE_RESERVED_C));
  endfunction : line_wired

  // field position of a line inside its priority register
  function automatic int field_lsb(input int n);
    field_lsb = (n % `PIR_FIELDS_PER_REG) * `PIR_FIELD_STRIDE
      + `PIR_PRIO_LSB;
  endfunction : field_lsb

  // true when priority register idx holds the field of line n
  function automatic logic prio_reg_hit(input int idx, input int n);
    prio_reg_hit = (idx == n / `PIR_FIELDS_PER_REG);
  endfunction : prio_reg_hit

  // carrier toward the arbiter
  pir_arb_if arb_bus ();

  // controller pending and line enable state
  pir_mask_t pend_ff;
  pir_mask_t nxt_pend;
  pir_mask_t lena_ff;
  pir_mask_t nxt_lena;

  // one two-bit priority field per line
  pir_prio_t prio_ff [`PIR_NUM_LINES];
  pir_prio_t nxt_prio [`PIR_NUM_LINES];

  // sticky non-maskable request
  logic nmi_ff;
  logic nxt_nmi;

  // registered winner toward the core
  logic valid_ff;
  logic nxt_valid;
  pir_line_t line_ff;
  pir_line_t nxt_line;
  pir_prio_t level_ff;
  pir_prio_t nxt_level;

  // registered readback of the addressed register
  logic [31:0] prio_rd_ff;
  logic [31:0] nxt_prio_rd;

  // ========================================================================
  // one source per wired line, lines with no peripheral read as zero.
  // the line index is the peripheral's fixed slot:
  //   0-6 power manager, system control, watchdog, rtc, external
  //       controller, nonvolatile memory, dma; 7 reserved
  //   8 event system, 9-14 serial interfaces 0-5
  //   15-17 control timers 0-2, 18-22 basic timers 3-7
  //   23 adc, 24 comparators, 25 dac; 26-27 reserved, 28-31 absent
  for (genvar g = 0; g < `PIR_NUM_LINES; g++) begin : g_line
    if (line_wired(g)) begin : g_src
      pir_src #(
        .NFLAG(NFLAG)
      ) u_src (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cond(periph_cond[g]),
        .flag_clr_wr(flag_clr_wr[g]),
        .flag_clr_data(flag_clr_data[g]),
        .en_set_wr(en_set_wr[g]),
        .en_set_data(en_set_data[g]),
        .en_clr_wr(en_clr_wr[g]),
        .en_clr_data(en_clr_data[g]),
        .flag_status(irq_flag_status_reg[g]),
        .en_status(irq_enable_set_reg[g]),
        .req(periph_req[g])
      );
    end else begin : g_rsvd
      // reserved and unimplemented lines carry no source
      assign irq_flag_status_reg[g] = '0;
      assign irq_enable_set_reg[g] = '0;
      assign periph_req[g] = 1'b0;
    end
  end

  // ========================================================================
  // pending and line enable state; hardware sets beat software clears
  // a request at edge n is pending after n and reaches irq_valid one
  // edge later; limitation: while a peripheral holds its request the
  // pending bit cannot be retired, by ack or by software, so the
  // handler must clear the peripheral flag first
  always_comb begin
    nxt_pend = pend_ff;
    if (pending_clr_wr) begin
      nxt_pend = nxt_pend & ~pending_clear_bits;
    end
    if (valid_ff && irq_ack) begin
      // taking the exception retires the pending bit of the winner
      nxt_pend[line_ff] = 1'b0;
    end
    if (pending_set_wr) begin
      nxt_pend = nxt_pend | pending_set_bits;
    end
    nxt_pend = nxt_pend | periph_req;
    nxt_lena = lena_ff;
    if (line_en_clr_wr) begin
      nxt_lena = nxt_lena & ~line_enable_clear_bits;
    end
    if (line_en_set_wr) begin
      nxt_lena = nxt_lena | line_enable_set_bits;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= `PIR_LINE_MASK_RESET;
      lena_ff <= `PIR_LINE_MASK_RESET;
    end else begin
      pend_ff <= nxt_pend;
      lena_ff <= nxt_lena;
    end
  end

  // ========================================================================
  // eight priority registers, four two-bit fields each
  // fields live in the top two bits of each byte, the rest reads zero;
  // readback shows the value written in the same cycle
  always_comb begin
    for (int i = 0; i < `PIR_NUM_LINES; i++) begin
      nxt_prio[i] = prio_ff[i];
      if (prio_wr && prio_reg_hit(int'(prio_idx), i)) begin
        nxt_prio[i] = prio_wdata[field_lsb(i) +: `PIR_PRIO_W];
      end
    end
    // bits outside the fields read as zero
    nxt_prio_rd = '0;
    for (int i = 0; i < `PIR_NUM_LINES; i++) begin
      if (prio_reg_hit(int'(prio_idx), i)) begin
        nxt_prio_rd[field_lsb(i) +: `PIR_PRIO_W] = nxt_prio[i];
      end
    end
  end

  // fields reset to zero, the most urgent level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `PIR_NUM_LINES; i++) begin
        prio_ff[i] <= `PIR_PRIO_RESET;
      end
      prio_rd_ff <= '0;
    end else begin
      for (int i = 0; i < `PIR_NUM_LINES; i++) begin
        prio_ff[i] <= nxt_prio[i];
      end
      prio_rd_ff <= nxt_prio_rd;
    end
  end

  // ========================================================================
  // arbitration over lines that are both pending and enabled
  // a disabled line stays pending and is served once enabled
  assign arb_bus.cand = pend_ff & lena_ff;
  for (genvar g = 0; g < `PIR_NUM_LINES; g++) begin : g_prio
    assign arb_bus.prio[g] = prio_ff[g];
  end

  pir_arb u_arb (
    .bus(arb_bus.arb)
  );

  // winner is registered so the core sees clean data; an ack drops the
  // request for one cycle to let the retired pending bit settle
  // trade-off: a cycle of latency keeps the 32-way compare chain off
  // the core's input timing
  always_comb begin
    nxt_valid = arb_bus.found;
    nxt_line = arb_bus.line;
    nxt_level = arb_bus.level;
    if (valid_ff && irq_ack) begin
      nxt_valid = 1'b0;
    end
  end

  // line and level follow the arbiter even while not valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_ff <= 1'b0;
      line_ff <= '0;
      level_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      line_ff <= nxt_line;
      level_ff <= nxt_level;
    end
  end

  // ========================================================================
  // non-maskable request, sticky until cleared; a new event wins
  // it bypasses pending, enable and priority: a level of its own
  always_comb begin
    nxt_nmi = nmi_ff;
    if (eic_nmi_clr) begin
      nxt_nmi = 1'b0;
    end
    if (eic_nmi_cond) begin
      nxt_nmi = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_ff <= 1'b0;
    end else begin
      nmi_ff <= nxt_nmi;
    end
  end

  // ========================================================================
  // state views, all straight from flip-flops
  assign nmi_req = nmi_ff;
  assign pending_set_reg = pend_ff;
  assign line_enable_set_reg = lena_ff;
  assign prio_rdata = prio_rd_ff;

  // core side, one registered winner
  assign irq_valid = valid_ff;
  assign irq_line = line_ff;
  assign irq_level = level_ff;

endmodule : pir_top

`default_nettype wire

// ---- hdl/pir_defines.svh ----
// named constants of the peripheral interrupt routing block
// assumes inclusion by bare name from every file that needs a figure
`ifndef PIR_DEFINES_SVH
`define PIR_DEFINES_SVH

// ==========================================================================
// controller geometry
`define PIR_NUM_LINES 32
`define PIR_NUM_WIRED 28
`define PIR_LINE_W 5
`define PIR_PRIO_W 2
`define PIR_NUM_PRIO_REGS 8
`define PIR_PRIO_REG_IDX_W 3
`define PIR_FIELDS_PER_REG 4
`define PIR_FIELD_STRIDE 8
`define PIR_PRIO_LSB 6
`define PIR_PRIO_RESET 2'h0

// ==========================================================================
// fixed line assignment
`define PIR_LINE_POWER_MANAGER 5'h00
`define PIR_LINE_SYSTEM_CONTROL_UNIT 5'h01
`define PIR_LINE_WATCHDOG 5'h02
`define PIR_LINE_REAL_TIME_COUNTER 5'h03
`define PIR_LINE_EXTERNAL_IRQ_CONTROLLER 5'h04
`define PIR_LINE_NONVOLATILE_MEMORY_CONTROLLER 5'h05
`define PIR_LINE_DMA_CONTROLLER 5'h06
`define PIR_LINE_RESERVED_A 5'h07
`define PIR_LINE_EVENT_SYSTEM 5'h08
`define PIR_LINE_SERIAL_COMM_INTERFACE_0 5'h09
`define PIR_LINE_CONTROL_TIMER_COUNTER_0 5'h0F
`define PIR_LINE_BASIC_TIMER_COUNTER_3 5'h12
`define PIR_LINE_ANALOG_TO_DIGITAL 5'h17
`define PIR_LINE_ANALOG_COMPARATOR 5'h18
`define PIR_LINE_DIGITAL_TO_ANALOG 5'h19
`define PIR_LINE_RESERVED_B 5'h1A
`define PIR_LINE_RESERVED_C 5'h1B

// ==========================================================================
// per-peripheral flag count and reset values
`define PIR_NUM_FLAGS 8
`define PIR_LINE_MASK_RESET 32'h0000_0000

`endif

// ---- hdl/pir_pkg.sv ----
// types shared by the peripheral interrupt routing modules
// assumes pir_defines.svh is reachable on the include path
`default_nettype none
`include "pir_defines.svh"

package pir_pkg;

  // ========================================================================
  // line number and priority level
  typedef logic [`PIR_LINE_W-1:0] pir_line_t;
  typedef logic [`PIR_PRIO_W-1:0] pir_prio_t;
  typedef logic [`PIR_NUM_LINES-1:0] pir_mask_t;

endpackage : pir_pkg

`default_nettype wire

// ---- hdl/pir_arb_if.sv ----
// carrier between the controller core and its priority arbiter
// assumes pir_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

interface pir_arb_if;
  import pir_pkg::*;

  // ========================================================================
  // candidates in, winner out
  pir_mask_t cand;
  pir_prio_t prio [`PIR_NUM_LINES];
  logic found;
  pir_line_t line;
  pir_prio_t level;

  modport ctl (output cand, output prio, input found, input line,
    input level);
  modport arb (input cand, input prio, output found, output line,
    output level);
endinterface : pir_arb_if

`default_nettype wire

// ---- hdl/pir_src.sv ----
// one peripheral's flag status and enable set/clear pair
// assumes condition and write strobes come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

module pir_src #(
  parameter int NFLAG = `PIR_NUM_FLAGS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // interrupt conditions, one cycle or level
  input wire logic [NFLAG-1:0] cond,
  // software writes: ones act, zeros leave bits alone
  input wire logic flag_clr_wr,
  input wire logic [NFLAG-1:0] flag_clr_data,
  input wire logic en_set_wr,
  input wire logic [NFLAG-1:0] en_set_data,
  input wire logic en_clr_wr,
  input wire logic [NFLAG-1:0] en_clr_data,
  // state and combined request
  output logic [NFLAG-1:0] flag_status,
  output logic [NFLAG-1:0] en_status,
  output logic req
);
  import pir_pkg::*;

  logic [NFLAG-1:0] flag_ff;
  logic [NFLAG-1:0] nxt_flag;
  logic [NFLAG-1:0] en_ff;
  logic [NFLAG-1:0] nxt_en;

  // ========================================================================
  // flags and enables; a new condition beats a clear in the same cycle
  always_comb begin
    nxt_flag = flag_ff;
    if (flag_clr_wr) begin
      nxt_flag = nxt_flag & ~flag_clr_data;
    end
    nxt_flag = nxt_flag | cond;
    nxt_en = en_ff;
    if (en_clr_wr) begin
      nxt_en = nxt_en & ~en_clr_data;
    end
    if (en_set_wr) begin
      nxt_en = nxt_en | en_set_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= '0;
      en_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      en_ff <= nxt_en;
    end
  end

  // ========================================================================
  // gated flags ored into one request for the instance
  assign flag_status = flag_ff;
  assign en_status = en_ff;
  assign req = |(flag_ff & en_ff);

endmodule : pir_src

`default_nettype wire

// ---- hdl/pir_arb.sv ----
// priority arbiter over pending and enabled lines
// assumes the controller registers the winner before it leaves the block
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

module pir_arb (
  // candidates and winner
  pir_arb_if.arb bus
);
  import pir_pkg::*;

  // ========================================================================
  // lowest value wins; strict compare keeps the lowest line on a tie
  always_comb begin
    bus.found = 1'b0;
    bus.line = '0;
    bus.level = '0;
    for (int i = 0; i < `PIR_NUM_LINES; i++) begin
      if (bus.cand[i] && (!bus.found || bus.prio[i] < bus.level)) begin
        bus.found = 1'b1;
        bus.line = pir_line_t'(i);
        bus.level = bus.prio[i];
      end
    end
  end

endmodule : pir_arb

`default_nettype wire

// ---- tb/pir_properties.sv ----
// port checks for the peripheral interrupt routing block
// assumes binding into pir_top, one clock, reset_n async active low
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

module pir_properties #(
  parameter int NFLAG = `PIR_NUM_FLAGS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // peripheral side
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] irq_flag_status_reg,
  input wire logic [`PIR_NUM_LINES-1:0][NFLAG-1:0] irq_enable_set_reg,
  input wire pir_pkg::pir_mask_t periph_req,
  input wire logic eic_nmi_cond,
  input wire logic eic_nmi_clr,
  input wire logic nmi_req,
  // controller controls and state
  input wire logic pending_set_wr,
  input wire pir_pkg::pir_mask_t pending_set_bits,
  input wire logic line_en_set_wr,
  input wire pir_pkg::pir_mask_t line_enable_set_bits,
  input wire logic line_en_clr_wr,
  input wire pir_pkg::pir_mask_t line_enable_clear_bits,
  input wire pir_pkg::pir_mask_t pending_set_reg,
  input wire pir_pkg::pir_mask_t line_enable_set_reg,
  input wire logic prio_wr,
  input wire logic [31:0] prio_wdata,
  input wire logic [31:0] prio_rdata,
  // core side
  input wire logic irq_valid,
  input wire pir_pkg::pir_line_t irq_line,
  input wire logic irq_ack
);
  import pir_pkg::*;

  // ==========================================================================
  // helper: expected requests, candidates as the arbiter saw them
  pir_mask_t or_req;
  pir_mask_t nxt_cand;
  pir_mask_t cand_ff;
  always_comb begin
    for (int i = 0; i < `PIR_NUM_LINES; i++) begin
      or_req[i] = |(irq_flag_status_reg[i] & irq_enable_set_reg[i]);
    end
    nxt_cand = pending_set_reg & line_enable_set_reg;
  end
  // winner is registered, so compare against last cycle's candidates
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cand_ff <= '0;
    end else begin
      cand_ff <= nxt_cand;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // assertions
  a_req_is_or: assert property (periph_req == or_req)
    else $error("peripheral request not flag and enable");
  a_unwired_quiet: assert property (
    irq_flag_status_reg[31:26] == '0 && irq_flag_status_reg[7] == '0)
    else $error("unwired line shows a flag");
  a_req_sets_pend: assert property ((|periph_req) |=>
    (pending_set_reg & $past(periph_req)) == $past(periph_req))
    else $error("request did not set pending");
  a_sw_pend_set: assert property (pending_set_wr |=>
    (pending_set_reg & $past(pending_set_bits)) == $past(pending_set_bits))
    else $error("software pend set lost");
  a_line_en_set: assert property (line_en_set_wr |=>
    (line_enable_set_reg & $past(line_enable_set_bits))
    == $past(line_enable_set_bits))
    else $error("line enable set lost");
  a_line_en_clr: assert property (line_en_clr_wr && !line_en_set_wr |=>
    (line_enable_set_reg & $past(line_enable_clear_bits)) == '0)
    else $error("line enable clear ignored");
  a_valid_needs_cand: assert property (irq_valid |-> cand_ff[irq_line])
    else $error("request shown for a line not pending and enabled");
  a_cand_gives_valid: assert property (
    (|cand_ff) && !$past(irq_ack) |-> irq_valid)
    else $error("candidate present but no request");
  a_prio_readback: assert property (prio_wr |=>
    prio_rdata == ($past(prio_wdata) & 32'hC0C0C0C0))
    else $error("priority readback wrong");
  a_nmi_sticky: assert property (nmi_req && !eic_nmi_clr |=> nmi_req)
    else $error("nmi dropped without clear");
  a_nmi_set: assert property (eic_nmi_cond |=> nmi_req)
    else $error("nmi not raised");

  // ==========================================================================
  // main scenarios seen
  c_ack: cover property (irq_valid && irq_ack);
  c_nmi: cover property ($rose(nmi_req));
  c_req: cover property (|periph_req);
endmodule : pir_properties

bind pir_top pir_properties #(.NFLAG(NFLAG)) i_pir_properties (.core_clk,
  .reset_n, .irq_flag_status_reg, .irq_enable_set_reg, .periph_req,
  .eic_nmi_cond, .eic_nmi_clr, .nmi_req, .pending_set_wr, .pending_set_bits,
  .line_en_set_wr, .line_enable_set_bits, .line_en_clr_wr,
  .line_enable_clear_bits, .pending_set_reg, .line_enable_set_reg, .prio_wr,
  .prio_wdata, .prio_rdata, .irq_valid, .irq_line, .irq_ack);

`default_nettype wire

// ---- tb/pir_core_model.sv ----
// core stand-in: takes interrupt requests, promptly or slowly
// assumes irq_valid is registered on core_clk
`timescale 1ns/1ps
`default_nettype none

module pir_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // request from the routing block
  input wire logic irq_valid,
  // pacing from the bench
  input wire logic hold,
  input wire logic slow,
  // acknowledge
  output logic irq_ack
);
  int wait_ff;

  // ==========================================================================
  // one-cycle ack, then a dead cycle so acks never come closer than two
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      wait_ff <= 0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
    end else if (irq_valid === 1'b1 && !hold) begin
      if (wait_ff >= (slow ? 3 : 0)) begin
        irq_ack <= 1'b1;
        wait_ff <= 0;
      end else begin
        wait_ff <= wait_ff + 1;
      end
    end
  end
endmodule : pir_core_model

`default_nettype wire

// ---- tb/pir_tb_top.sv ----
// self-checking bench for the peripheral interrupt routing block
// assumes pir_top, pir_core_model and the checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "pir_defines.svh"

module pir_tb_top;
  import pir_pkg::*;
  logic core_clk, reset_n, eic_nmi_cond, eic_nmi_clr, nmi_req, hold, slow;
  logic [31:0][7:0] periph_cond, flag_clr_data, en_set_data, en_clr_data;
  logic [31:0][7:0] irq_flag_status_reg, irq_enable_set_reg;
  logic [31:0] flag_clr_wr, en_set_wr, en_clr_wr, prio_wdata, prio_rdata;
  pir_mask_t periph_req, pending_set_bits, pending_clear_bits, pending_set_reg;
  pir_mask_t line_enable_set_bits, line_enable_clear_bits, line_enable_set_reg;
  logic pending_set_wr, pending_clr_wr, line_en_set_wr, line_en_clr_wr;
  logic prio_wr, irq_valid, irq_ack, ok;
  logic [2:0] prio_idx;
  logic [7:0] m;
  pir_line_t irq_line;
  pir_prio_t irq_level;
  pir_prio_t psh [32];
  pir_mask_t sh, len_sh;
  int fails, n_checks, cyc, w, wa, b;

  pir_top #(.NFLAG(8)) i_pir_top (.core_clk, .reset_n, .periph_cond,
    .flag_clr_wr, .flag_clr_data, .en_set_wr, .en_set_data, .en_clr_wr,
    .en_clr_data, .irq_flag_status_reg, .irq_enable_set_reg, .periph_req,
    .eic_nmi_cond, .eic_nmi_clr, .nmi_req, .pending_set_wr, .pending_set_bits,
    .pending_clr_wr, .pending_clear_bits, .line_en_set_wr,
    .line_enable_set_bits, .line_en_clr_wr, .line_enable_clear_bits,
    .pending_set_reg, .line_enable_set_reg, .prio_wr, .prio_idx, .prio_wdata,
    .prio_rdata, .irq_valid, .irq_line, .irq_level, .irq_ack);
  pir_core_model i_pir_core_model (.core_clk, .reset_n, .irq_valid, .hold,
    .slow, .irq_ack);

  // ==========================================================================
  // helpers
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic tick;
    @(negedge core_clk);
  endtask : tick
  task automatic idle;
    {flag_clr_wr, en_set_wr, en_clr_wr, pending_set_wr, pending_clr_wr} = '0;
    {line_en_set_wr, line_en_clr_wr, prio_wr, eic_nmi_cond, eic_nmi_clr} = '0;
    periph_cond = '0;
  endtask : idle
  // strobes live one edge, results read one edge later
  task automatic go;
    tick();
    idle();
    tick();
  endtask : go
  // lowest level wins, ties to the lowest line
  function automatic int win(pir_mask_t c);
    int r;
    r = -1;
    for (int i = 0; i < 32; i++) begin
      if (c[i] && (r < 0 || psh[i] < psh[r])) r = i;
    end
    return r;
  endfunction : win
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // clock, hang guard, ack monitor against the bench's own arbitration
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
    if (irq_ack === 1'b1 && irq_valid === 1'b1) begin
      wa = win(sh & len_sh);
      cmp("ack_line", wa, irq_line);
      cmp("ack_level", psh[wa], irq_level);
      sh[wa] = 1'b0;
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    idle();
    {flag_clr_data, en_set_data, en_clr_data, prio_wdata, prio_idx} = '0;
    {pending_set_bits, pending_clear_bits} = '0;
    {line_enable_set_bits, line_enable_clear_bits} = '0;
    {reset_n, hold, slow, sh, len_sh} = '0;
    hold = 1'b1;
    void'($urandom(32'h9E34321B));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    tick();
    cmp("pend_rst", 32'h0, pending_set_reg);
    cmp("out_rst", 32'h0, {irq_valid, nmi_req, prio_rdata[29:0]});
    // each line: flag, enable set/clear, request and pending
    for (int g = 0; g < 32; g++) begin
      b = $urandom_range(7);
      m = 8'($urandom);
      ok = !(g == 7 || g > 25);
      periph_cond[g][b] = 1'b1;
      en_set_wr[g] = 1'b1;
      en_set_data[g] = m;
      go();
      cmp("flags", ok ? 32'(8'h01 << b) : 32'h0, irq_flag_status_reg[g]);
      cmp("enables", ok ? m : 8'h00, irq_enable_set_reg[g]);
      cmp("req", ok & m[b], periph_req[g]);
      cmp("pend", ok & m[b], pending_set_reg[g]);
      en_clr_wr[g] = 1'b1;
      en_clr_data[g] = 8'h01 << b;
      go();
      cmp("enables", ok ? m & ~(8'h01 << b) : 8'h00, irq_enable_set_reg[g]);
      cmp("req", 1'b0, periph_req[g]);
      cmp("valid", 1'b0, irq_valid);
      flag_clr_wr[g] = 1'b1;
      flag_clr_data[g] = 8'hFF;
      pending_clr_wr = 1'b1;
      pending_clear_bits = 32'hFFFFFFFF;
      go();
    end
    // priority registers, readback of the two-bit fields only
    for (int k = 0; k < 8; k++) begin
      prio_wr = 1'b1;
      prio_idx = 3'(k);
      prio_wdata = $urandom;
      for (int j = 0; j < 4; j++) psh[k * 4 + j] = prio_wdata[j * 8 + 6 +: 2];
      go();
      cmp("prio", prio_wdata & 32'hC0C0C0C0, prio_rdata);
    end
    // arbitration rounds, enable set and clear together in even rounds, core drains
    for (int r = 0; r < 8; r++) begin
      slow = 1'($urandom);
      {pending_set_wr, line_en_clr_wr} = 2'h3;
      // odd rounds clear lines without setting any
      line_en_set_wr = (r % 2 == 0);
      pending_set_bits = $urandom;
      line_enable_set_bits = $urandom;
      line_enable_clear_bits = $urandom;
      sh |= pending_set_bits;
      len_sh = (len_sh & ~line_enable_clear_bits)
        | (line_en_set_wr ? line_enable_set_bits : 32'h0);
      go();
      cmp("pend", sh, pending_set_reg);
      cmp("lines", len_sh, line_enable_set_reg);
      w = win(sh & len_sh);
      cmp("valid", w >= 0, irq_valid);
      if (w >= 0) cmp("line", w, irq_line);
      hold = 1'b0;
      for (int t = 0; t < 400 && (sh & len_sh) != 0; t++) tick();
      hold = 1'b1;
      cmp("drained", 32'h0, sh & len_sh);
    end
    // nmi: sticky, set wins over clear
    eic_nmi_cond = 1'b1;
    go();
    cmp("nmi", 1'b1, nmi_req);
    {eic_nmi_cond, eic_nmi_clr} = 2'h3;
    go();
    cmp("nmi", 1'b1, nmi_req);
    eic_nmi_clr = 1'b1;
    go();
    cmp("nmi", 1'b0, nmi_req);
    close_out();
  end
endmodule : pir_tb_top

`default_nettype wire
